// [sirm_pkg.sv]
package sirm_pkg;
	// register map
	localparam logic [3:0] ADDR_CSR = 4'h0;
	localparam logic [3:0] ADDR_CFG = 4'h4;
	localparam int BIT_SRC_SEL = 7;
	localparam int BIT_IRQ_EN = 6;
	localparam int BIT_LEVEL = 5;
	localparam int BIT_SUPPLY_RF = 4;
	localparam int BIT_WDG_RF = 0;
	localparam logic [7:0] CSR_RESET = 8'h00;
	// reset delay
	localparam int CLK_MHZ = 100;
	localparam int DELAY_SHORT_CYC = 256;
	localparam int DELAY_LONG_CYC = 4096;
	// minimum output reset pulse
	localparam int PULSE_MIN_NS = 20000;
	localparam int PULSE_MIN_CYC = (PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int FETCH_CYC = 2;
	typedef enum logic [1:0] {
		SIRM_RUN,
		SIRM_ACTIVE,
		SIRM_DELAY
	} sirm_state_t;
endpackage

// [sirm_monitor.sv]
// The Avalon-MM interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - low supply holds chip reset, line low
// - watchdog underflow drives line for minimum pulse
// - detector present and threshold set by option
// - aux detector inactive when detector disabled
// - bit 5 shows synced comparator level
// - bit 7 selects supply or sense pin
// - bit 6 enables irq on both edges
// - pending irq cleared on service entry
// - irq needs enable and cleared cpu mask
// - irq wakes wait, not halt
// - register frozen during halt
// - no rising irq within reset delay
// - enabling while low gives immediate irq
// - supply flag set on low-supply reset
// - pin and watchdog resets keep supply flag
// - watchdog flag set, cleared by write, supply reset or pin reset
// - flag pair encodes reset cause
// - flags unreliable when detector disabled
// - control bits reset zero, flags keep cause
// - 256 or 4096 cycle delay after reset
module sirm_monitor #(
	parameter int DELAY_LONG = sirm_pkg::DELAY_LONG_CYC
) (
	// clock, reset, enable
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	// nonvolatile options
	input wire logic low_supply_detector_en_i,
	input wire logic [1:0] low_supply_detector_level_i,
	input wire logic long_delay_i,
	// analog and reset sources
	input wire logic low_supply_detector_i,
	input wire logic aux_supply_cmp_i,
	input wire logic aux_sense_pin_cmp_i,
	input wire logic watchdog_underflow_i,
	input wire logic reset_line_in_i,
	// cpu side
	input wire logic cpu_irq_masked_i,
	input wire logic irq_ack_i,
	input wire logic halt_i,
	input wire logic wait_i,
	// avalon-mm slave
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// outputs
	output logic reset_line_o,
	output logic reset_line_oe_o,
	output logic chip_reset_o,
	output logic irq_o,
	output logic wake_o,
	output logic [1:0] threshold_sel_o,
	output logic aux_src_sel_o
);

	logic [1:0] supply_sync;
	logic [1:0] aux_sup_sync;
	logic [1:0] aux_pin_sync;
	logic [1:0] line_sync;
	logic low_supply;
	logic line_low;
	logic wdg_event;
	logic wdg_prev;
	sirm_pkg::sirm_state_t state;
	logic [15:0] count;
	logic cause_supply;
	logic cause_wdg;
	logic source_select;
	logic irq_enable;
	logic level;
	logic level_valid;
	logic supply_flag;
	logic wdg_flag;
	logic pending;
	logic in_reset;
	logic bus_done;
	logic wr_csr;
	logic [15:0] delay_cyc;
	logic [2:0] oe_hist;
	logic line_low_ext;

	assign low_supply = low_supply_detector_en_i & supply_sync[1];
	assign line_low = ~line_sync[1];
	// own drive echoes through the synchroniser, ignore it
	assign line_low_ext = line_low & ~reset_line_oe_o & (oe_hist == 3'h0);
	assign wdg_event = watchdog_underflow_i & ~wdg_prev;
	assign in_reset = (state != sirm_pkg::SIRM_RUN);
	assign delay_cyc = long_delay_i ? DELAY_LONG[15:0] : 16'(sirm_pkg::DELAY_SHORT_CYC);
	assign wr_csr = avs_write & bus_done & (avs_address == sirm_pkg::ADDR_CSR) & ~halt_i;

	// input synchronisers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			supply_sync <= 2'h0;
			aux_sup_sync <= 2'h0;
			aux_pin_sync <= 2'h0;
			line_sync <= 2'h3;
			wdg_prev <= 1'b0;
			oe_hist <= 3'h7;
		end else if (ce_i) begin
			oe_hist <= {oe_hist[1:0], reset_line_oe_o};
			supply_sync <= {supply_sync[0], low_supply_detector_i};
			aux_sup_sync <= {aux_sup_sync[0], aux_supply_cmp_i};
			aux_pin_sync <= {aux_pin_sync[0], aux_sense_pin_cmp_i};
			line_sync <= {line_sync[0], reset_line_in_i};
			wdg_prev <= watchdog_underflow_i;
		end
	end

	// reset sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= sirm_pkg::SIRM_ACTIVE;
			count <= 16'h0000;
			cause_supply <= 1'b1;
			cause_wdg <= 1'b0;
		end else if (ce_i) begin
			if (low_supply) begin
				state <= sirm_pkg::SIRM_ACTIVE;
				count <= 16'h0000;
				cause_supply <= 1'b1;
			end else if (wdg_event) begin
				state <= sirm_pkg::SIRM_ACTIVE;
				count <= 16'h0000;
				cause_wdg <= 1'b1;
			end else begin
				case (state)
					sirm_pkg::SIRM_RUN: begin
						if (line_low_ext) begin
							state <= sirm_pkg::SIRM_ACTIVE;
							count <= 16'h0000;
						end
					end
					sirm_pkg::SIRM_ACTIVE: begin
						if (count < 16'(sirm_pkg::PULSE_MIN_CYC)) begin
							count <= count + 16'h0001;
						end else begin
							state <= sirm_pkg::SIRM_DELAY;
							count <= 16'h0000;
						end
					end
					sirm_pkg::SIRM_DELAY: begin
						if (count + 16'h0001 >= delay_cyc) begin
							state <= sirm_pkg::SIRM_RUN;
							count <= 16'h0000;
							cause_supply <= 1'b0;
							cause_wdg <= 1'b0;
						end else begin
							count <= count + 16'h0001;
						end
					end
					default: state <= sirm_pkg::SIRM_ACTIVE;
				endcase
			end
		end
	end

	// reset line and chip reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			reset_line_o <= 1'b0;
			reset_line_oe_o <= 1'b1;
			chip_reset_o <= 1'b1;
		end else if (ce_i) begin
			reset_line_o <= 1'b0;
			reset_line_oe_o <= in_reset | low_supply | wdg_event;
			chip_reset_o <= in_reset | low_supply;
		end
	end

	// option passthrough
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			threshold_sel_o <= 2'h0;
			aux_src_sel_o <= 1'b0;
		end else if (ce_i) begin
			threshold_sel_o <= low_supply_detector_level_i;
			aux_src_sel_o <= source_select & low_supply_detector_en_i;
		end
	end

	// control bits
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			source_select <= sirm_pkg::CSR_RESET[sirm_pkg::BIT_SRC_SEL];
			irq_enable <= sirm_pkg::CSR_RESET[sirm_pkg::BIT_IRQ_EN];
		end else if (ce_i) begin
			if (in_reset) begin
				source_select <= 1'b0;
				irq_enable <= 1'b0;
			end else if (wr_csr) begin
				source_select <= avs_writedata[sirm_pkg::BIT_SRC_SEL];
				irq_enable <= avs_writedata[sirm_pkg::BIT_IRQ_EN];
			end
		end
	end

	// reset cause flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			supply_flag <= 1'b1;
			wdg_flag <= 1'b0;
		end else if (ce_i) begin
			if (low_supply) begin
				supply_flag <= 1'b1;
				wdg_flag <= 1'b0;
			end else if (wdg_event) begin
				wdg_flag <= 1'b1;
			end else if (in_reset && !cause_supply && !cause_wdg && state == sirm_pkg::SIRM_ACTIVE) begin
				wdg_flag <= 1'b0;
			end else if (wr_csr && !halt_i) begin
				if (!avs_writedata[sirm_pkg::BIT_SUPPLY_RF]) begin
					supply_flag <= 1'b0;
				end
				if (!avs_writedata[sirm_pkg::BIT_WDG_RF]) begin
					wdg_flag <= 1'b0;
				end
			end
		end
	end

	// aux level and pending interrupt
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			level <= 1'b0;
			level_valid <= 1'b0;
			pending <= 1'b0;
		end else if (ce_i && !halt_i) begin
			if (!low_supply_detector_en_i || in_reset) begin
				level <= 1'b0;
				level_valid <= 1'b0;
				pending <= 1'b0;
			end else begin
				level <= source_select ? aux_pin_sync[1] : aux_sup_sync[1];
				level_valid <= 1'b1;
				if (irq_enable && level_valid && (level != (source_select ? aux_pin_sync[1]
						: aux_sup_sync[1]))) begin
					pending <= 1'b1;
				end else if (wr_csr && avs_writedata[sirm_pkg::BIT_IRQ_EN] && !irq_enable
						&& level) begin
					pending <= 1'b1;
				end else if (irq_ack_i) begin
					pending <= 1'b0;
				end
			end
		end
	end

	// interrupt and wake outputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_o <= 1'b0;
			wake_o <= 1'b0;
		end else if (ce_i) begin
			irq_o <= pending & irq_enable & ~cpu_irq_masked_i;
			wake_o <= pending & irq_enable & wait_i & ~halt_i;
		end
	end

	// avalon slave, one wait cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_done <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else if (ce_i) begin
			bus_done <= (avs_read | avs_write) & ~bus_done;
			avs_waitrequest <= ~((avs_read | avs_write) & ~bus_done);
			if (avs_read && !bus_done) begin
				case (avs_address)
					sirm_pkg::ADDR_CSR: avs_readdata <= {24'h000000, source_select, irq_enable,
						level, supply_flag, 3'h0, wdg_flag};
					sirm_pkg::ADDR_CFG: avs_readdata <= {27'h0000000, long_delay_i,
						low_supply_detector_level_i, low_supply_detector_en_i};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

endmodule

// [sirm_line_model.sv]
`timescale 1ns/1ns
// shared reset wire, pull-up, pulled low by device or outside circuit
module sirm_line_model (
	input wire logic dut_oe_i,
	input wire logic ext_pull_i,
	output logic line_o
);
	assign line_o = !(dut_oe_i || ext_pull_i);
endmodule

// [sirm_assertions.sv]
`timescale 1ns/1ns
module sirm_assertions (
	// inputs
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic low_supply_detector_en_i,
	input wire logic low_supply_detector_i,
	input wire logic watchdog_underflow_i,
	input wire logic cpu_irq_masked_i,
	input wire logic halt_i,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	// outputs
	input wire logic avs_waitrequest,
	input wire logic reset_line_oe_o,
	input wire logic chip_reset_o,
	input wire logic irq_o,
	input wire logic wake_o,
	input wire logic aux_src_sel_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	a_supply_line: assert property ((low_supply_detector_en_i && low_supply_detector_i) [*4]
		|-> reset_line_oe_o) else $error("line free in low supply");
	a_supply_hold: assert property ((low_supply_detector_en_i && low_supply_detector_i) [*4]
		|-> chip_reset_o) else $error("chip free in low supply");
	a_wdg_pulse: assert property ($rose(watchdog_underflow_i) |-> ##[1:3] reset_line_oe_o [*8])
		else $error("watchdog pulse short");
	a_irq_masked: assert property (irq_o |-> !$past(cpu_irq_masked_i))
		else $error("irq while masked");
	a_aux_gated: assert property (!low_supply_detector_en_i |-> !irq_o)
		else $error("irq with detector off");
	a_src_write: assert property (avs_write && !avs_waitrequest && !halt_i && !chip_reset_o
		&& low_supply_detector_en_i |=> ##1 aux_src_sel_o == $past(avs_writedata[7], 2))
		else $error("source select not written");
	a_halt_frozen: assert property (halt_i [*3] |-> $stable(aux_src_sel_o))
		else $error("register moved in halt");
	a_halt_sleep: assert property (halt_i [*2] |-> !wake_o)
		else $error("wake in halt");
	c_irq: cover property ($rose(irq_o));
	c_wake: cover property ($rose(wake_o));
	c_boot: cover property ($fell(chip_reset_o));
endmodule
bind sirm_monitor sirm_assertions u_chk (.*);

// [tb_top.sv]
`timescale 1ns/1ns
module tb_top;
	logic clk_i = 1'h0, rst_i = 1'h1, ce_i = 1'h1, long_delay_i = 1'h0, ext_pull = 1'h0;
	logic low_supply_detector_en_i = 1'h1, low_supply_detector_i = 1'h0;
	logic [1:0] low_supply_detector_level_i = 2'h2, threshold_sel_o;
	logic aux_supply_cmp_i = 1'h0, aux_sense_pin_cmp_i = 1'h0, watchdog_underflow_i = 1'h0;
	logic cpu_irq_masked_i = 1'h0, irq_ack_i = 1'h0, halt_i = 1'h0, wait_i = 1'h0;
	logic avs_read = 1'h0, avs_write = 1'h0, avs_waitrequest, reset_line_in_i;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0, avs_readdata;
	logic reset_line_oe_o, chip_reset_o, irq_o, wake_o, aux_src_sel_o;
	logic [15:0] notes[$];
	logic [15:0] n;
	logic [7:0] d;
	int mismatches = 0, check_count = 0, seed = 57485, i;
	always #5 clk_i = ~clk_i;
	sirm_line_model far (.dut_oe_i(reset_line_oe_o), .ext_pull_i(ext_pull),
		.line_o(reset_line_in_i));
	sirm_monitor #(.DELAY_LONG(64)) dut (.*, .reset_line_o());
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] wd,
		input logic [15:0] note);
		cyc(1);
		avs_address <= a;
		avs_writedata <= {24'h0, wd};
		avs_write <= wr;
		avs_read <= !wr;
		if (!wr) notes.push_back(note);
		do cyc(1); while (avs_waitrequest !== 1'h0);
		avs_write <= 1'h0;
		avs_read <= 1'h0;
	endtask
	task automatic rd(input logic [15:0] note);
		bus(1'h0, 4'h0, 8'h0, note);
	endtask
	task automatic wr(input logic [7:0] wd);
		bus(1'h1, 4'h0, wd, 16'h0);
	endtask
	task automatic settle;
		i = 0;
		cyc(4);
		while (chip_reset_o !== 1'h0 && i < 9000) begin
			cyc(1);
			i++;
		end
		chk(8'(i > sirm_pkg::PULSE_MIN_CYC + sirm_pkg::DELAY_SHORT_CYC - 50), 8'h01);
	endtask
	task automatic wdg;
		watchdog_underflow_i <= 1'h1;
		cyc(1);
		watchdog_underflow_i <= 1'h0;
		settle();
	endtask
	task automatic ack;
		irq_ack_i <= 1'h1;
		cyc(1);
		irq_ack_i <= 1'h0;
	endtask
	task automatic drive(input int s, input logic v);
		if (s == 1) aux_sense_pin_cmp_i <= v;
		else aux_supply_cmp_i <= v;
	endtask
	task automatic irq_is(input logic v);
		for (int w = 0; w < 20 && irq_o !== v; w++) cyc(1);
		chk(8'(irq_o), 8'(v));
	endtask
	// read results against the oldest note
	always @(posedge clk_i) begin
		if (avs_read && avs_waitrequest === 1'h0) begin
			n = notes.pop_front();
			chk(avs_readdata[7:0] & n[15:8], n[7:0]);
		end
	end
	initial begin
		cyc(12);
		rst_i <= 1'h0;
		settle();
		chk(8'(threshold_sel_o), 8'h02);
		rd(16'hEE00);
		bus(1'h0, 4'h8, 8'h0, 16'hFF00);
		low_supply_detector_i <= 1'h1;
		cyc(20);
		low_supply_detector_i <= 1'h0;
		settle();
		rd(16'hFF10);
		wdg();
		rd(16'hFF11);
		wr(8'h00);
		rd(16'hFF00);
		wdg();
		rd(16'hFF01);
		ext_pull <= 1'h1;
		cyc(20);
		ext_pull <= 1'h0;
		settle();
		rd(16'hFF00);
		repeat (4) begin
			d = 8'($random(seed)) & 8'hC0;
			wr(d);
			rd({8'hFF, d});
		end
		for (int s = 0; s < 2; s++) begin
			wr({s[0], 7'h40});
			drive(1 - s, 1'h1);
			cyc(10);
			irq_is(1'h0);
			drive(1 - s, 1'h0);
			drive(s, 1'h1);
			irq_is(1'h1);
			rd(16'h2020);
			ack();
			irq_is(1'h0);
			cpu_irq_masked_i <= 1'h1;
			drive(s, 1'h0);
			cyc(10);
			irq_is(1'h0);
			cpu_irq_masked_i <= 1'h0;
			irq_is(1'h1);
			ack();
		end
		wr(8'h00);
		drive(0, 1'h1);
		cyc(10);
		wr(8'h40);
		irq_is(1'h1);
		ack();
		irq_is(1'h0);
		drive(0, 1'h0);
		irq_is(1'h1);
		ack();
		wait_i <= 1'h1;
		drive(0, 1'h1);
		cyc(10);
		chk(8'(wake_o), 8'h01);
		ack();
		wait_i <= 1'h0;
		halt_i <= 1'h1;
		drive(0, 1'h0);
		wr(8'h80);
		rd(16'hC040);
		halt_i <= 1'h0;
		ack();
		rst_i <= 1'h1;
		low_supply_detector_en_i <= 1'h0;
		cyc(12);
		rst_i <= 1'h0;
		settle();
		wr(8'h40);
		drive(0, 1'h1);
		cyc(10);
		irq_is(1'h0);
		tally_and_finish();
	end
	initial begin
		#1000000;
		mismatches++;
		tally_and_finish();
	end
endmodule
